// file: inc/trs_pkg.sv
package trs_pkg;
    // selector codes as software sees them
    localparam logic [7:0] TRS_SEL_NONE = 8'h00;   // sel_none
    localparam logic [7:0] TRS_SEL_COAX = 8'h02;   // sel_faceplate_coax
    localparam logic [7:0] TRS_SEL_SWLV = 8'h03;   // sel_software_level
    localparam logic [7:0] TRS_SEL_BP0 = 8'h6F;    // sel_backplane_line0 (111)
    localparam logic [7:0] TRS_SEL_BP7 = 8'h76;    // sel_backplane_line7 (118)
    localparam int TRS_LINES = 8;                  // backplane trigger lines
    localparam logic TRS_SWLV_RST = 1'b0;          // software level after reset

    // status codes returned with each answer
    typedef enum logic [2:0] {
        TRS_ST_OK = 3'h0,        // no error
        TRS_ST_NOINIT = 3'h1,    // status_not_initialised
        TRS_ST_PATH = 3'h2,      // route could not be set
        TRS_ST_CLR = 3'h3,       // clear failed
        TRS_ST_QUERY = 3'h4,     // query failed
        TRS_ST_BUSY = 3'h5       // open while already open
    } trs_status_t;

    // operation codes on the command port
    typedef enum logic [2:0] {
        TRS_OP_OPEN = 3'h0,      // routing_open
        TRS_OP_RELEASE = 3'h1,   // routing_release
        TRS_OP_SWWR = 3'h2,      // sw_level_write
        TRS_OP_SWRD = 3'h3,      // sw_level_read
        TRS_OP_SELECT = 3'h4,    // path_select
        TRS_OP_CLEAR = 3'h5,     // path_clear
        TRS_OP_READBK = 3'h6     // path_readback
    } trs_op_t;

    // one routing path
    typedef struct packed {
        logic [7:0] src;         // source code
        logic [7:0] dst;         // destination code
        logic [7:0] mid;         // intermediate code
    } trs_path_t;

    // command from software
    typedef struct packed {
        trs_op_t op;             // operation
        logic level;             // level for sw_level_write
        trs_path_t path;         // path for path_select
    } trs_cmd_t;

    // answer to software
    typedef struct packed {
        trs_status_t status;     // outcome
        logic level;             // software level readback
        trs_path_t path;         // path readback
    } trs_rsp_t;

    localparam trs_path_t TRS_PATH_NONE = '{TRS_SEL_NONE, TRS_SEL_NONE, TRS_SEL_NONE};
endpackage : trs_pkg

// file: hdl/trs_path_check.sv
`timescale 1ns/1ps
// validates a requested path against the legal selector sets
module trs_path_check (
    input wire trs_pkg::trs_path_t path,   // requested path
    output logic ok                        // path is legal
);
    import trs_pkg::*;

    // code names one backplane line
    function automatic logic trs_is_line(input logic [7:0] c);
        return (c >= TRS_SEL_BP0) && (c <= TRS_SEL_BP7);
    endfunction : trs_is_line

    wire src_ok;   // source in allowed set
    wire dst_ok;   // destination in allowed set
    wire mid_ok;   // intermediate consistent with route
    wire sw_coax;  // software level to the faceplate
    wire not_loop; // source and destination differ

    assign src_ok = (path.src == TRS_SEL_COAX) || (path.src == TRS_SEL_SWLV)
                    || trs_is_line(path.src);
    // software level can never be a destination
    assign dst_ok = (path.dst == TRS_SEL_COAX) || trs_is_line(path.dst);
    assign sw_coax = (path.src == TRS_SEL_SWLV) && (path.dst == TRS_SEL_COAX);
    // only software-to-faceplate passes through a line, all else names none
    assign mid_ok = sw_coax ? trs_is_line(path.mid) : (path.mid == TRS_SEL_NONE);
    assign not_loop = (path.src != path.dst);
    assign ok = src_ok && dst_ok && mid_ok && not_loop;
endmodule : trs_path_check

// file: hdl/trs_switch.sv
`timescale 1ns/1ps
// Summary of operation
// - software command produces a TTL trigger
// - software level follows written 0 or 1
// - level low after reset, readable back
// - route trigger between faceplate and backplane
// - sources: faceplate, software level, lines 0-7
// - destinations: faceplate or lines; never software
// - intermediate line only for software-to-faceplate
// - clear removes route, reports OK status
// - readback returns source, destination, intermediate
// - source codes 0,2,3,111-118
// - destination codes 0,2,111-118
// - intermediate codes 0 or 111-118
module trs_switch (
    input wire mclk,                            // 25 MHz clock
    input wire rst_b,                           // async reset, active low
    input wire ce,                              // clock enable, freezes all state
    input wire cmd_valid,                       // command strobe, one cycle
    input wire trs_pkg::trs_cmd_t cmd,          // command word
    output trs_pkg::trs_rsp_t rsp,              // answer word
    output logic rsp_valid,                     // answer strobe, one cycle
    output logic is_open,                       // routing has been opened
    output logic sw_level,                      // present software level
    input wire coax_in,                         // faceplate connector input level
    output logic coax_out,                      // faceplate connector drive level
    output logic coax_oe,                       // faceplate connector driven
    input wire [7:0] bp_in,                     // backplane lines input level
    output logic [7:0] bp_out,                  // backplane lines drive level
    output logic [7:0] bp_oe                    // backplane lines driven
);
    import trs_pkg::*;

    // one-hot command sequencer
    typedef enum logic [1:0] {
        TRS_IDLE = 2'b01,   // waiting for a command
        TRS_ANS = 2'b10     // presenting the answer
    } trs_state_t;

    // line index of a backplane code
    // the subtraction wraps for codes that are not lines; callers guard with trs_is_line
    function automatic logic [2:0] trs_line_idx(input logic [7:0] c);
        logic [7:0] d;
        d = c - TRS_SEL_BP0;
        return d[2:0];
    endfunction : trs_line_idx

    // code names one backplane line; used for source, destination and intermediate
    function automatic logic trs_is_line(input logic [7:0] c);
        return (c >= TRS_SEL_BP0) && (c <= TRS_SEL_BP7);
    endfunction : trs_is_line

    // enable mask with a single line set
    function automatic logic [7:0] trs_line_mask(input logic [2:0] i);
        return 8'h01 << i;
    endfunction : trs_line_mask

    trs_state_t state_r, state_nxt;   // sequencer
    logic open_r;                     // opened flag
    logic swlv_r;                     // software level
    trs_path_t path_r;                // active path
    trs_rsp_t rsp_r, rsp_nxt;         // answer register
    logic rsp_valid_r;                // answer strobe, high in the answer state
    logic coax_out_r, coax_oe_r;      // faceplate drive
    logic [7:0] bp_out_r, bp_oe_r;    // backplane drive

    wire path_ok;                     // requested path legal
    wire take;                        // command accepted this cycle
    wire allowed;                     // operation permitted now
    wire src_level;                   // level of the selected source
    wire [2:0] src_idx;               // source line index
    wire [2:0] dst_idx;               // destination line index
    wire [2:0] mid_idx;               // intermediate line index
    wire src_is_line;                 // source is a backplane line
    wire dst_is_line;                 // destination is a backplane line
    wire mid_is_line;                 // intermediate is a backplane line
    wire [7:0] dst_mask;              // enable claimed by the destination
    wire [7:0] mid_mask;              // enable claimed by the intermediate
    wire [7:0] bp_oe_nxt;             // line enables for the next cycle
    wire coax_oe_nxt;                 // faceplate enable for the next cycle

    trs_path_check u_check (
        .path(cmd.path),
        .ok(path_ok)
    );

    assign take = ce && cmd_valid && (state_r == TRS_IDLE);
    // before opening only open itself is served
    assign allowed = open_r || (cmd.op == TRS_OP_OPEN);
    assign src_idx = trs_line_idx(path_r.src);
    assign dst_idx = trs_line_idx(path_r.dst);
    assign mid_idx = trs_line_idx(path_r.mid);
    assign src_is_line = trs_is_line(path_r.src);
    assign dst_is_line = trs_is_line(path_r.dst);
    assign mid_is_line = trs_is_line(path_r.mid);
    // destination and intermediate each claim one line; the rest stay released
    // so that other cards on the backplane remain free to drive them
    assign dst_mask = dst_is_line ? trs_line_mask(dst_idx) : 8'h00;
    assign mid_mask = mid_is_line ? trs_line_mask(mid_idx) : 8'h00;
    assign bp_oe_nxt = dst_mask | mid_mask;
    assign coax_oe_nxt = (path_r.dst == TRS_SEL_COAX);
    // source level: faceplate, software level, or a line
    assign src_level = (path_r.src == TRS_SEL_COAX) ? coax_in :
                       (path_r.src == TRS_SEL_SWLV) ? swlv_r :
                       src_is_line ? bp_in[src_idx] : 1'b0;

    // sequencer and answer builder
    // every command taken in the idle state gets exactly one answer, refused ones included, so
    // software never has to guess whether a request was seen
    always_comb begin
        state_nxt = state_r;
        rsp_nxt = rsp_r;
        case (state_r)
            TRS_IDLE: begin
                if (take) begin
                    state_nxt = TRS_ANS;
                    rsp_nxt.status = TRS_ST_OK;
                    rsp_nxt.level = swlv_r;
                    rsp_nxt.path = TRS_PATH_NONE;
                    if (!allowed) begin
                        rsp_nxt.status = TRS_ST_NOINIT;
                    end else if (cmd.op == TRS_OP_OPEN && open_r) begin
                        rsp_nxt.status = TRS_ST_BUSY; // reopening is refused
                    end else if (cmd.op == TRS_OP_SELECT && !path_ok) begin
                        rsp_nxt.status = TRS_ST_PATH;
                    end else if (cmd.op == TRS_OP_SWWR) begin
                        rsp_nxt.level = cmd.level; // answer shows the new level
                    end else if (cmd.op == TRS_OP_SELECT) begin
                        rsp_nxt.path = cmd.path;
                    end else if (cmd.op == TRS_OP_READBK) begin
                        rsp_nxt.path = path_r;
                    end else if (cmd.op > TRS_OP_READBK) begin
                        rsp_nxt.status = TRS_ST_QUERY; // unknown operation
                    end
                end
            end
            TRS_ANS: begin
                state_nxt = TRS_IDLE;   // answer stands one cycle
            end
            default: begin
                state_nxt = TRS_IDLE;
            end
        endcase
    end

    // sequencer and answer registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= TRS_IDLE;
            rsp_r <= '0;
            rsp_valid_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            rsp_r <= rsp_nxt;
            rsp_valid_r <= (state_nxt == TRS_ANS);
        end
    end

    // open flag; release is expected from software before exit
    // open gates every level and route change, so a stray command before open
    // leaves level, route and pins as reset left them and only draws a refusal
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            open_r <= 1'b0;
        end else if (take && cmd.op == TRS_OP_OPEN) begin
            open_r <= 1'b1;
        end else if (take && open_r && cmd.op == TRS_OP_RELEASE) begin
            open_r <= 1'b0;
        end
    end

    // software level register
    // the level survives release; only reset or a write of 0 brings it back to low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            swlv_r <= TRS_SWLV_RST;
        end else if (take && open_r && cmd.op == TRS_OP_SWWR) begin
            swlv_r <= cmd.level;
        end
    end

    // active path; release also drops the route so lines float
    // a rejected path keeps the old route, so a bad request never drops a live trigger
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            path_r <= TRS_PATH_NONE;
        end else if (take && open_r && cmd.op == TRS_OP_SELECT && path_ok) begin
            path_r <= cmd.path;
        end else if (take && open_r && cmd.op == TRS_OP_CLEAR) begin
            path_r <= TRS_PATH_NONE;
        end else if (take && open_r && cmd.op == TRS_OP_RELEASE) begin
            path_r <= TRS_PATH_NONE;
        end
    end

    // pin drivers, registered so the outputs come from flops; one cycle lag
    // the lag costs one cycle of trigger latency but keeps the pins glitch free
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            coax_out_r <= 1'b0;
            coax_oe_r <= 1'b0;
            bp_out_r <= 8'h00;
            bp_oe_r <= 8'h00;
        end else if (ce) begin
            coax_out_r <= src_level;
            coax_oe_r <= coax_oe_nxt;
            bp_out_r <= {TRS_LINES{src_level}}; // only enabled lines carry it
            bp_oe_r <= bp_oe_nxt;
        end
    end

    assign rsp = rsp_r;
    assign rsp_valid = rsp_valid_r;
    assign is_open = open_r;
    assign sw_level = swlv_r;
    assign coax_out = coax_out_r;
    assign coax_oe = coax_oe_r;
    assign bp_out = bp_out_r;
    assign bp_oe = bp_oe_r;
endmodule : trs_switch

// file: verification/trs_far_side.sv
`timescale 1ns/1ps
// far side: backplane lines pulled up, faceplate coax terminated low
module trs_far_side (
    input wire [7:0] bp_out, // switch line levels
    input wire [7:0] bp_oe, // switch line enables
    input wire coax_out, // switch faceplate level
    input wire coax_oe, // switch faceplate enable
    input wire [7:0] far_en, // other cards driving lines
    input wire [7:0] far_val, // their levels
    input wire ext_en, // cable source driving the connector
    input wire ext_val, // its level
    output logic [7:0] bp_in, // resolved line levels
    output logic coax_in // resolved faceplate level
);
    // a released line falls to another card's level or to its termination, so a stale level never survives
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            bp_in[i] = bp_oe[i] ? bp_out[i] : (far_en[i] ? far_val[i] : 1'b1);
        end
        coax_in = coax_oe ? coax_out : (ext_en ? ext_val : 1'b0);
    end
endmodule : trs_far_side

// file: verification/trs_switch_assertions.sv
`timescale 1ns/1ps
// the command checks hang off a command the switch really took; the rest watch answer and level
module trs_switch_assertions (
    input wire mclk, // clock
    input wire rst_b, // async reset, active low
    input wire ce, // clock enable
    input wire cmd_valid, // command strobe
    input wire trs_pkg::trs_cmd_t cmd, // command word
    input wire trs_pkg::trs_rsp_t rsp, // answer word
    input wire rsp_valid, // answer strobe
    input wire is_open, // opened flag
    input wire sw_level, // software level
    input wire coax_oe, // faceplate enable
    input wire [7:0] bp_oe // line enables
);
    import trs_pkg::*;
    logic take; // command accepted this edge
    logic shut; // command other than open accepted while not opened
    assign take = ce && cmd_valid && !rsp_valid;
    assign shut = take && !is_open && cmd.op != TRS_OP_OPEN;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_answer_next: assert property (take |=> rsp_valid)
        else $error("no answer after command");
    a_answer_pulse: assert property (rsp_valid && ce |=> !rsp_valid)
        else $error("answer longer than one cycle");
    a_shut_refused: assert property (shut |=> rsp.status == TRS_ST_NOINIT && !is_open)
        else $error("unopened command not refused");
    a_shut_no_route: assert property (shut |-> ##1 (bp_oe == 8'h00 && !coax_oe) [*2])
        else $error("route driven while unopened");
    a_open_sets: assert property (take && cmd.op == TRS_OP_OPEN |=> is_open)
        else $error("open did not set open flag");
    a_level_copy: assert property (take && is_open && cmd.op == TRS_OP_SWWR
        |=> sw_level == $past(cmd.level) && rsp.status == TRS_ST_OK)
        else $error("software level not written");
    a_level_hold: assert property ($changed(sw_level)
        |-> $past(take) && $past(cmd.op) inside {TRS_OP_SWWR, TRS_OP_RELEASE})
        else $error("software level moved without a write");
    a_dest_not_sw: assert property (take && is_open && cmd.op == TRS_OP_SELECT
        && cmd.path.dst == TRS_SEL_SWLV |=> rsp.status == TRS_ST_PATH)
        else $error("software level accepted as destination");
    a_release_closes: assert property (take && is_open && cmd.op == TRS_OP_RELEASE
        |=> !is_open ##1 (bp_oe == 8'h00 && !coax_oe))
        else $error("release left routing alive");
    a_mid_code: assert property (rsp_valid && rsp.path.mid != TRS_SEL_NONE
        |-> rsp.path.mid >= TRS_SEL_BP0 && rsp.path.mid <= TRS_SEL_BP7)
        else $error("intermediate code out of range");
    c_refused: cover property (shut ##1 rsp_valid);
    c_path_bad: cover property (rsp_valid && rsp.status == TRS_ST_PATH);
    c_busy: cover property (rsp_valid && rsp.status == TRS_ST_BUSY);
    c_frozen: cover property (!ce && cmd_valid ##1 !rsp_valid);
endmodule : trs_switch_assertions
bind trs_switch trs_switch_assertions i_chk (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .rsp_valid(rsp_valid), .is_open(is_open),
    .sw_level(sw_level), .coax_oe(coax_oe), .bp_oe(bp_oe));

// file: verification/trs_switch_tb_top.sv
`timescale 1ns/1ps
// directed bench: commands from software, trigger traffic from the far side
module trs_switch_tb_top;
    import trs_pkg::*;
    logic mclk, rst_b, ce, cmd_valid, rsp_valid, is_open, sw_level; // control side
    logic coax_in, coax_out, coax_oe, ext_en, ext_val; // faceplate side
    logic [7:0] bp_in, bp_out, bp_oe, far_en, far_val; // backplane side
    trs_cmd_t cmd; // command under way
    trs_rsp_t rsp, got; // live answer and captured answer
    int miscompares = 0;
    int checks = 0;
    trs_switch i_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp(rsp), .rsp_valid(rsp_valid), .is_open(is_open), .sw_level(sw_level),
        .coax_in(coax_in), .coax_out(coax_out), .coax_oe(coax_oe), .bp_in(bp_in),
        .bp_out(bp_out), .bp_oe(bp_oe));
    trs_far_side i_far (.bp_out(bp_out), .bp_oe(bp_oe), .coax_out(coax_out),
        .coax_oe(coax_oe), .far_en(far_en), .far_val(far_val), .ext_en(ext_en),
        .ext_val(ext_val), .bp_in(bp_in), .coax_in(coax_in));
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk_v(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk_v
    task automatic chk_st(input trs_status_t g, input trs_status_t e);
        chk_v(32'(g), 32'(e), "status");
    endtask : chk_st
    function automatic trs_path_t pth(input int s, input int d, input int m);
        return '{8'(s), 8'(d), 8'(m)};
    endfunction : pth
    // entered at a falling edge; the answer is judged in its single answer cycle
    task automatic issue(input trs_op_t op, input logic lv, input trs_path_t p,
        input trs_status_t es);
        cmd = '{op, lv, p};
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        chk_v(32'(rsp_valid), 1, "no answer");
        chk_st(rsp.status, es);
        got = rsp;
        @(negedge mclk); // the answer cycle ignores commands, so stay idle
    endtask : issue
    // two edges: the pin register takes the new input level at the first, the second is margin
    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask : settle
    task automatic t_refuse;
        chk_v({is_open, sw_level, coax_oe, bp_oe}, 0, "reset state");
        for (int o = 1; o < 7; o++) issue(trs_op_t'(o), 1'b1, pth(2, 111, 0), TRS_ST_NOINIT);
        chk_v({is_open, sw_level, coax_oe, bp_oe}, 0, "state moved");
        issue(TRS_OP_OPEN, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        issue(TRS_OP_OPEN, 1'b0, TRS_PATH_NONE, TRS_ST_BUSY);
        issue(trs_op_t'(7), 1'b0, TRS_PATH_NONE, TRS_ST_QUERY);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_lines;
        for (int i = 0; i < 8; i++) begin
            issue(TRS_OP_SELECT, 1'b0, pth(111 + i, 2, 0), TRS_ST_OK);
            far_en[i] = 1'b1;
            for (int v = 0; v < 2; v++) begin
                far_val[i] = v[0];
                settle();
                chk_v({coax_oe, coax_out}, {1'b1, v[0]}, "line to coax");
            end
            far_en = 8'h00;
            issue(TRS_OP_READBK, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
            chk_v(got.path, pth(111 + i, 2, 0), "source code");
            issue(TRS_OP_SELECT, 1'b0, pth(2, 111 + i, 0), TRS_ST_OK);
            ext_en = 1'b1;
            for (int v = 0; v < 2; v++) begin
                ext_val = v[0];
                settle();
                chk_v({bp_oe[i], bp_out[i]}, {1'b1, v[0]}, "coax to line");
            end
            ext_en = 1'b0;
            issue(TRS_OP_READBK, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
            chk_v(got.path, pth(2, 111 + i, 0), "destination code");
        end
        $display("test lines done");
    endtask : t_lines
    task automatic t_soft;
        issue(TRS_OP_SWRD, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        chk_v(32'(got.level), 0, "level after reset");
        issue(TRS_OP_SELECT, 1'b0, pth(3, 2, 114), TRS_ST_OK);
        issue(TRS_OP_SWWR, 1'b1, TRS_PATH_NONE, TRS_ST_OK);
        settle();
        chk_v({coax_oe, coax_out, bp_oe[3], bp_out[3]}, 4'hF, "soft high");
        issue(TRS_OP_SWRD, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        chk_v(32'(got.level), 1, "level readback");
        issue(TRS_OP_SWWR, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        settle();
        chk_v({coax_oe, coax_out}, 2'h2, "soft low");
        issue(TRS_OP_SELECT, 1'b0, pth(2, 3, 0), TRS_ST_PATH);
        issue(TRS_OP_SELECT, 1'b0, pth(3, 2, 0), TRS_ST_PATH);
        issue(TRS_OP_SELECT, 1'b0, pth(111, 2, 112), TRS_ST_PATH);
        issue(TRS_OP_READBK, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        chk_v(got.path, pth(3, 2, 114), "path kept");
        issue(TRS_OP_CLEAR, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        issue(TRS_OP_READBK, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        chk_v(got.path, 0, "clear path");
        chk_v({coax_oe, bp_oe}, 0, "clear pins");
        issue(TRS_OP_RELEASE, 1'b0, TRS_PATH_NONE, TRS_ST_OK);
        issue(TRS_OP_SWRD, 1'b0, TRS_PATH_NONE, TRS_ST_NOINIT);
        $display("test soft done");
    endtask : t_soft
    // clock enable low: a pending command and a moving input change nothing
    task automatic t_freeze;
        ce = 1'b0;
        cmd = '{TRS_OP_SWWR, 1'b1, TRS_PATH_NONE};
        cmd_valid = 1'b1;
        {ext_en, ext_val} = 2'b11;
        repeat (3) @(negedge mclk);
        chk_v({rsp_valid, sw_level, bp_out[7]}, 0, "frozen");
        cmd_valid = 1'b0;
        ce = 1'b1;
        settle();
        chk_v({sw_level, bp_oe[7], bp_out[7]}, 3'h3, "thawed");
        ext_en = 1'b0;
        $display("test freeze done");
    endtask : t_freeze
    // reset for 12 cycles, then the scenarios in order
    initial begin
        {rst_b, cmd_valid, far_en, far_val, ext_en, ext_val} = '0;
        ce = 1'b1; // clock enable runs until t_freeze lowers it
        cmd = '0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        t_refuse();
        t_lines();
        t_freeze();
        t_soft();
        give_verdict();
    end
endmodule : trs_switch_tb_top
